// [verilog/vlu_pkg.sv]
// Package of opcodes, field positions and constants for the logical unit
// Behaviour
// - Every result registered with one cycle latency
// - Bitwise AND, OR, XOR and inverted-first variants
// - Boolean AND/NAND/OR/NOR to general or branch
// - Select on branch bit, false-sense inverts it
// - Moves between branch and general registers
// - Extracts decode only immediate bits eight to zero
// - Small extract: length-1 in 8:5, position 4:0
// - Large extract: bits 8:5 hold length minus 17
// - Signed extracts sign-extend, unsigned zero-extend
// - Length plus position over 32 raises trap
// - Rotate left, shift left, logical shift right
// - Arbitrary sign/zero extend, byte and half cases
// - Boolean conversions between branch and general
// - Byte select per lane from four condition bits
// - Negated byte select inverts each condition bit
// - Word from source pair at byte 1/2/3
// - Dynamic extracts take byte offset from branch
// - Truncating pack keeps low byte of halves
// - Saturating half pack clamps to signed 16 bits
// - Unsigned byte pack clamps to 0..255
// - Rounding pack: upper half, ties toward positive
// - Unpack upper/lower bytes; join low halves
package vlu_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned OP_W = 6;
  localparam int unsigned IMM_USED_MSB = 8;
  localparam int unsigned LEN_MSB = 8;
  localparam int unsigned LEN_LSB = 5;
  localparam int unsigned POS_MSB = 4;
  localparam int unsigned POS_LSB = 0;
  localparam logic [5:0] LARGE_LEN_BASE = 6'h11;
  localparam logic [5:0] SMALL_LEN_BASE = 6'h01;
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [5:0] HALF_BITS = 6'h10;
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;

  typedef enum logic [5:0] {
    OP_AND, OP_ANDC, OP_OR, OP_ORC, OP_XOR,
    OP_ANDL, OP_NANDL, OP_ORL, OP_NORL,
    OP_SELECT, OP_SELECT_F,
    OP_MOV,
    OP_EXTRACT, OP_EXTRACTU, OP_EXTRACTL, OP_EXTRACTLU,
    OP_ROTL, OP_SHL, OP_SHRU, OP_SXT, OP_ZXT,
    OP_SXTB, OP_SXTH, OP_ZXTB, OP_ZXTH,
    OP_CONV_B2I, OP_CONV_I2B,
    OP_BYTE_LANE_SELECT, OP_BYTE_LANE_SELECT_NEGATED,
    OP_WORD_FROM_BYTE_ONE, OP_WORD_FROM_BYTE_TWO, OP_WORD_FROM_BYTE_THREE,
    OP_DYNAMIC_LEFT_EXTRACT, OP_DYNAMIC_RIGHT_EXTRACT,
    OP_TRUNCATING_BYTE_PACK, OP_SATURATING_HALF_PACK,
    OP_UNSIGNED_SATURATING_BYTE_PACK, OP_ROUNDING_HALF_PACK,
    OP_BYTE_PERMUTE, OP_SHUFFLE_BYTE_HIGH, OP_SHUFFLE_BYTE_LOW,
    OP_SHUFFLE_HALF_HIGH, OP_SHUFFLE_HALF_LOW,
    OP_EVEN_BYTE_SHUFFLE, OP_ODD_BYTE_SHUFFLE,
    OP_UNPACK_HIGH, OP_UNPACK_LOW, OP_LOW_HALF_JOIN
  } vlu_op_t;

endpackage : vlu_pkg

// [verilog/vlu_logical_unit.sv]
// One-cycle logical and packed-byte datapath of the integer ALU
`timescale 1ns/100ps
module vlu_logical_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Issue
  input wire logic issue_valid_i,
  input wire logic [5:0] op_i,
  input wire logic src2_is_imm_i,
  input wire logic dest_is_branch_i,
  input wire logic src_is_branch_i,
  // Operands
  input wire logic [31:0] src1_i,
  input wire logic [31:0] src2_i,
  input wire logic [31:0] imm_i,
  input wire logic [3:0] branch_condition_source_i,
  input wire logic [3:0] bsrc1_i,
  input wire logic [3:0] bsrc2_i,
  // Results
  output logic result_valid_o,
  output logic [31:0] result_o,
  output logic bresult_valid_o,
  output logic [3:0] bresult_o,
  output logic illegal_instruction_trap_o
);

  logic [31:0] opb;
  logic [31:0] res;
  logic [3:0] bres;
  logic bwr;
  logic ill;
  logic [5:0] len;
  logic [4:0] pos;
  logic [4:0] amt;
  logic [63:0] pair;
  logic [31:0] shifted;
  logic [5:0] wid;
  // Decoded extract and shift qualifiers
  logic ext_large;
  logic ext_signed;
  logic shift_over;
  // Per-lane results from the lane modules
  wire logic [31:0] lane_sel;
  wire logic [31:0] lane_perm;
  logic t1;
  logic t2;
  logic [3:0] cond;
  logic [1:0] boff;
  logic [31:0] rnd1;
  logic [31:0] rnd2;
  vlu_pkg::vlu_op_t op;

  function automatic logic [15:0] sat16(input logic [31:0] v);
    if ($signed(v) > $signed(32'h0000_7FFF)) begin
      sat16 = 16'h7FFF;
    end else if ($signed(v) < $signed(32'hFFFF_8000)) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  function automatic logic [7:0] usat8(input logic [15:0] v);
    if (v[15]) begin
      usat8 = 8'h00;
    end else if (v > 16'h00FF) begin
      usat8 = 8'hFF;
    end else begin
      usat8 = v[7:0];
    end
  endfunction : usat8

  // Round upper half to nearest, ties toward positive
  function automatic logic [15:0] rnp16(input logic [31:0] v);
    logic [32:0] s;
    s = {v[31], v} + 33'h0_0000_8000;
    if (s[32:31] == 2'b01) begin
      rnp16 = 16'h7FFF;
    end else begin
      rnp16 = s[31:16];
    end
  endfunction : rnp16

  // Keep the low w bits, sign- or zero-extending above
  function automatic logic [31:0] ext_w(input logic [31:0] v,
                                        input logic [5:0] w,
                                        input logic sgn);
    logic [31:0] m;
    m = (w >= vlu_pkg::WORD_BITS) ? 32'hFFFF_FFFF :
        ((32'h0000_0001 << w[4:0]) - 32'h0000_0001);
    if (w == 6'h00) begin
      ext_w = 32'h0000_0000;
    end else if (sgn && v[w[4:0] - 5'h01]) begin
      ext_w = v | ~m;
    end else begin
      ext_w = v & m;
    end
  endfunction : ext_w

  always_comb begin
    op = vlu_pkg::vlu_op_t'(op_i);
    opb = src2_is_imm_i ? imm_i : src2_i;
    amt = opb[4:0];
    // Large extracts bias the length field by seventeen
    ext_large = (op == vlu_pkg::OP_EXTRACTL) ||
                (op == vlu_pkg::OP_EXTRACTLU);
    // Signed extracts copy the field's top bit upwards
    ext_signed = (op == vlu_pkg::OP_EXTRACT) ||
                 (op == vlu_pkg::OP_EXTRACTL);
    // Shift amounts of 32 or more clear the word
    shift_over = opb[31:5] != 27'h0;
    pos = imm_i[vlu_pkg::POS_MSB:vlu_pkg::POS_LSB];
    len = {2'b00, imm_i[vlu_pkg::LEN_MSB:vlu_pkg::LEN_LSB]} +
          (ext_large ?
           vlu_pkg::LARGE_LEN_BASE : vlu_pkg::SMALL_LEN_BASE);
    shifted = src1_i >> pos;
    wid = (opb[31:6] != 26'h0) ? vlu_pkg::WORD_BITS : opb[5:0];
    if (wid > vlu_pkg::WORD_BITS) begin
      wid = vlu_pkg::WORD_BITS;
    end
    t1 = src_is_branch_i ? bsrc1_i[0] : (src1_i != 32'h0);
    t2 = src_is_branch_i ? bsrc2_i[0] :
         (src2_is_imm_i ? (imm_i != 32'h0) : (src2_i != 32'h0));
    cond = (op == vlu_pkg::OP_BYTE_LANE_SELECT_NEGATED) ?
           ~branch_condition_source_i : branch_condition_source_i;
    boff = branch_condition_source_i[1:0];
    pair = {src2_i, src1_i};
    rnd1 = {16'h0, rnp16(src1_i)};
    rnd2 = {16'h0, rnp16(src2_i)};
    res = 32'h0;
    bres = 4'h0;
    bwr = 1'b0;
    ill = 1'b0;
    case (op)
      // Bitwise primitives
      vlu_pkg::OP_AND: res = src1_i & opb;
      vlu_pkg::OP_ANDC: res = ~src1_i & opb;
      vlu_pkg::OP_OR: res = src1_i | opb;
      vlu_pkg::OP_ORC: res = ~src1_i | opb;
      vlu_pkg::OP_XOR: res = src1_i ^ opb;
      // Boolean primitives on truth values
      vlu_pkg::OP_ANDL, vlu_pkg::OP_NANDL,
      vlu_pkg::OP_ORL, vlu_pkg::OP_NORL: begin
        case (op)
          vlu_pkg::OP_ANDL: res[0] = t1 & t2;
          vlu_pkg::OP_NANDL: res[0] = ~(t1 & t2);
          vlu_pkg::OP_ORL: res[0] = t1 | t2;
          default: res[0] = ~(t1 | t2);
        endcase
        bres = {3'b000, res[0]};
        bwr = dest_is_branch_i;
      end
      // Scalar selects and moves
      vlu_pkg::OP_SELECT:
        res = branch_condition_source_i[0] ? src1_i : opb;
      vlu_pkg::OP_SELECT_F:
        res = ~branch_condition_source_i[0] ? src1_i : opb;
      vlu_pkg::OP_MOV: begin
        res = src_is_branch_i ? {28'h0, bsrc1_i} : src1_i;
        bres = src_is_branch_i ? bsrc1_i : src1_i[3:0];
        bwr = dest_is_branch_i;
      end
      // Bit-field extracts; an overlong field traps instead
      vlu_pkg::OP_EXTRACT, vlu_pkg::OP_EXTRACTU,
      vlu_pkg::OP_EXTRACTL, vlu_pkg::OP_EXTRACTLU: begin
        ill = ({1'b0, len} + {2'b00, pos}) > {1'b0, vlu_pkg::WORD_BITS};
        res = ill ? 32'h0 : ext_w(shifted, len, ext_signed);
      end
      // Rotate and shifts
      vlu_pkg::OP_ROTL: res = (src1_i << amt) |
                              (src1_i >> ((6'h20 - {1'b0, amt}) & 6'h1F));
      vlu_pkg::OP_SHL: res = shift_over ? 32'h0 : src1_i << amt;
      vlu_pkg::OP_SHRU: res = shift_over ? 32'h0 : src1_i >> amt;
      // Arbitrary and fixed-width extensions
      vlu_pkg::OP_SXT: res = ext_w(src1_i, wid, 1'b1);
      vlu_pkg::OP_ZXT: res = ext_w(src1_i, wid, 1'b0);
      vlu_pkg::OP_SXTB: res = ext_w(src1_i, vlu_pkg::BYTE_BITS, 1'b1);
      vlu_pkg::OP_SXTH: res = ext_w(src1_i, vlu_pkg::HALF_BITS, 1'b1);
      vlu_pkg::OP_ZXTB: res = ext_w(src1_i, vlu_pkg::BYTE_BITS, 1'b0);
      vlu_pkg::OP_ZXTH: res = ext_w(src1_i, vlu_pkg::HALF_BITS, 1'b0);
      // Boolean conversions
      vlu_pkg::OP_CONV_B2I: res = {31'h0, bsrc1_i[0]};
      vlu_pkg::OP_CONV_I2B: begin
        bres = {3'b000, src1_i != 32'h0};
        bwr = 1'b1;
      end
      // Packed byte selects come from the lane multiplexers
      vlu_pkg::OP_BYTE_LANE_SELECT, vlu_pkg::OP_BYTE_LANE_SELECT_NEGATED:
        res = lane_sel;
      // Word extracts from the source pair
      vlu_pkg::OP_WORD_FROM_BYTE_ONE: res = pair[39:8];
      vlu_pkg::OP_WORD_FROM_BYTE_TWO: res = pair[47:16];
      vlu_pkg::OP_WORD_FROM_BYTE_THREE: res = pair[55:24];
      vlu_pkg::OP_DYNAMIC_RIGHT_EXTRACT:
        res = pair[{boff, 3'b000} +: 32];
      vlu_pkg::OP_DYNAMIC_LEFT_EXTRACT:
        res = pair[(6'h20 - {1'b0, boff, 3'b000}) +: 32];
      // Packs, src1 fills the low half
      vlu_pkg::OP_TRUNCATING_BYTE_PACK:
        res = {src2_i[23:16], src2_i[7:0], src1_i[23:16], src1_i[7:0]};
      vlu_pkg::OP_SATURATING_HALF_PACK:
        res = {sat16(src2_i), sat16(src1_i)};
      vlu_pkg::OP_UNSIGNED_SATURATING_BYTE_PACK:
        res = {usat8(src2_i[31:16]), usat8(src2_i[15:0]),
               usat8(src1_i[31:16]), usat8(src1_i[15:0])};
      vlu_pkg::OP_ROUNDING_HALF_PACK:
        res = {rnd2[15:0], rnd1[15:0]};
      // Unpacks and half join
      vlu_pkg::OP_UNPACK_HIGH:
        res = {8'h00, src1_i[31:24], 8'h00, src1_i[23:16]};
      vlu_pkg::OP_UNPACK_LOW:
        res = {8'h00, src1_i[15:8], 8'h00, src1_i[7:0]};
      vlu_pkg::OP_LOW_HALF_JOIN: res = {src2_i[15:0], src1_i[15:0]};
      // Permute and shuffles
      vlu_pkg::OP_BYTE_PERMUTE: res = lane_perm;
      vlu_pkg::OP_SHUFFLE_BYTE_HIGH:
        res = {src2_i[31:24], src1_i[31:24], src2_i[23:16], src1_i[23:16]};
      vlu_pkg::OP_SHUFFLE_BYTE_LOW:
        res = {src2_i[15:8], src1_i[15:8], src2_i[7:0], src1_i[7:0]};
      vlu_pkg::OP_SHUFFLE_HALF_HIGH:
        res = {src2_i[31:16], src1_i[31:16]};
      vlu_pkg::OP_SHUFFLE_HALF_LOW:
        res = {src2_i[15:0], src1_i[15:0]};
      vlu_pkg::OP_EVEN_BYTE_SHUFFLE:
        res = {opb[23:16], opb[7:0], src1_i[23:16], src1_i[7:0]};
      vlu_pkg::OP_ODD_BYTE_SHUFFLE:
        res = {opb[31:24], opb[15:8], src1_i[31:24], src1_i[15:8]};
      default: res = 32'h0;
    endcase
  end

  // One lane slice per byte: select multiplexer and permute picker
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      // Condition bit high takes src1's byte
      vlu_lane_mux2 #(
        .LANE_W(8)
      ) u_sel (
        .sel_i(cond[g]),
        .a_i(src1_i[g*8 +: 8]),
        .b_i(opb[g*8 +: 8]),
        .y_o(lane_sel[g*8 +: 8])
      );
      // Two selector bits per lane pick a source byte
      vlu_lane_pick4 #(
        .LANE_W(8)
      ) u_perm (
        .sel_i(opb[g*2 +: 2]),
        .word_i(src1_i),
        .y_o(lane_perm[g*8 +: 8])
      );
    end
  endgenerate

  // General result lands one cycle after issue
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      result_valid_o <= 1'b0;
      result_o <= vlu_pkg::RESULT_RST;
    end else begin
      result_valid_o <= issue_valid_i && !bwr && !ill &&
                        (op != vlu_pkg::OP_CONV_I2B);
      result_o <= res;
    end
  end

  // Branch result lands one cycle after issue
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bresult_valid_o <= 1'b0;
      bresult_o <= 4'h0;
    end else begin
      bresult_valid_o <= issue_valid_i && bwr;
      bresult_o <= bres;
    end
  end

  // Trap pulse for an overlong extract field
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      illegal_instruction_trap_o <= 1'b0;
    end else begin
      illegal_instruction_trap_o <= issue_valid_i && ill;
    end
  end

endmodule : vlu_logical_unit

// Two-way lane multiplexer, a_i taken while sel_i is high
module vlu_lane_mux2 #(
  parameter int unsigned LANE_W = 8
) (
  // Select
  input wire logic sel_i,
  // Lanes
  input wire logic [LANE_W-1:0] a_i,
  input wire logic [LANE_W-1:0] b_i,
  // Result
  output logic [LANE_W-1:0] y_o
);

  assign y_o = sel_i ? a_i : b_i;

endmodule : vlu_lane_mux2

// Four-way lane picker, one lane of a four-lane word
module vlu_lane_pick4 #(
  parameter int unsigned LANE_W = 8
) (
  // Select
  input wire logic [1:0] sel_i,
  // Word
  input wire logic [4*LANE_W-1:0] word_i,
  // Result
  output logic [LANE_W-1:0] y_o
);

  assign y_o = word_i[sel_i*LANE_W +: LANE_W];

endmodule : vlu_lane_pick4

// [sim/vlu_issue_model.sv]
// Issue stage model driving operands into the logical unit
`timescale 1ns/100ps
module vlu_issue_model (
  // Clock
  input wire logic clk_i,
  // Issue
  output logic issue_valid_o,
  output logic [5:0] op_o,
  output logic [2:0] flag_o,
  // Operands
  output logic [31:0] src1_o,
  output logic [31:0] src2_o,
  output logic [31:0] imm_o,
  output logic [3:0] bc_o
);
  initial begin
    issue_valid_o = 1'b0;
    {op_o, flag_o, src1_o, src2_o, imm_o, bc_o} = '0;
  end
  // One issue; operands turn to garbage once the slot is gone
  task automatic issue(logic [5:0] o, logic [31:0] x, y, z, logic [3:0] c,
                       logic [2:0] f);
    @(posedge clk_i);
    issue_valid_o <= 1'b1;
    {op_o, src1_o, src2_o, imm_o, bc_o, flag_o} <= {o, x, y, z, c, f};
    @(posedge clk_i);
    issue_valid_o <= 1'b0;
    {src1_o, src2_o, imm_o, bc_o} <= ~{x, y, z, c};
  endtask : issue
endmodule : vlu_issue_model

// [sim/vlu_logical_unit_assertions.sv]
// Checker of the logical unit's port behaviour
`timescale 1ns/100ps
module vlu_chk (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic issue_valid_i,
  input wire logic [5:0] op_i,
  input wire logic src2_is_imm_i,
  input wire logic [31:0] src1_i,
  input wire logic [31:0] src2_i,
  input wire logic [31:0] imm_i,
  input wire logic [3:0] branch_condition_source_i,
  input wire logic result_valid_o,
  input wire logic [31:0] result_o,
  input wire logic illegal_instruction_trap_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [31:0] b;
  logic is_l;
  logic is_x;
  logic [6:0] span;
  assign b = src2_is_imm_i ? imm_i : src2_i;
  assign is_l = op_i == vlu_pkg::OP_EXTRACTL || op_i == vlu_pkg::OP_EXTRACTLU;
  assign is_x = issue_valid_i && (is_l || op_i == vlu_pkg::OP_EXTRACT ||
                op_i == vlu_pkg::OP_EXTRACTU);
  assign span = imm_i[8:5] + (is_l ? 7'h11 : 7'h01) + imm_i[4:0];
  property p_lat;
    result_valid_o |-> $past(issue_valid_i);
  endproperty
  a_lat: assert property (p_lat) else $error("result without issue");
  property p_and;
    issue_valid_i && op_i == vlu_pkg::OP_AND |=>
      result_valid_o && result_o == $past(src1_i & b);
  endproperty
  a_and: assert property (p_and) else $error("and wrong");
  property p_orc;
    issue_valid_i && op_i == vlu_pkg::OP_ORC |=> result_o == $past(~src1_i | b);
  endproperty
  a_orc: assert property (p_orc) else $error("orc wrong");
  property p_sel;
    issue_valid_i && op_i == vlu_pkg::OP_SELECT |=> result_o ==
      ($past(branch_condition_source_i[0]) ? $past(src1_i) : $past(b));
  endproperty
  a_sel: assert property (p_sel) else $error("select wrong");
  property p_trap;
    is_x && span > 7'h20 |=> illegal_instruction_trap_o && !result_valid_o;
  endproperty
  a_trap: assert property (p_trap) else $error("no trap");
  property p_ok;
    is_x && span <= 7'h20 |=> result_valid_o && !illegal_instruction_trap_o;
  endproperty
  a_ok: assert property (p_ok) else $error("bad trap");
  property p_shru;
    issue_valid_i && op_i == vlu_pkg::OP_SHRU && b < 32'h20 |=>
      result_o == $past(src1_i >> b[4:0]);
  endproperty
  a_shru: assert property (p_shru) else $error("shru wrong");
  property p_w1;
    issue_valid_i && op_i == vlu_pkg::OP_WORD_FROM_BYTE_ONE |=>
      result_o == $past({src2_i[7:0], src1_i[31:8]});
  endproperty
  a_w1: assert property (p_w1) else $error("byte one wrong");
  property p_pack;
    issue_valid_i && op_i == vlu_pkg::OP_TRUNCATING_BYTE_PACK |=> result_o ==
      $past({src2_i[23:16], src2_i[7:0], src1_i[23:16], src1_i[7:0]});
  endproperty
  a_pack: assert property (p_pack) else $error("pack wrong");
endmodule : vlu_chk
bind vlu_logical_unit vlu_chk u_chk (.clk_i, .srst_i, .issue_valid_i, .op_i,
  .src2_is_imm_i, .src1_i, .src2_i, .imm_i, .branch_condition_source_i,
  .result_valid_o, .result_o, .illegal_instruction_trap_o);

// [sim/tb_top.sv]
// Self-checking bench for the logical unit
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic iv, rv, bv, trap;
  logic [5:0] op;
  logic [2:0] fl;
  logic [31:0] a, b, im, res;
  logic [3:0] bc, bres;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  always #20 clk_i = ~clk_i;
  vlu_issue_model u_iss (.clk_i, .issue_valid_o(iv), .op_o(op), .flag_o(fl),
    .src1_o(a), .src2_o(b), .imm_o(im), .bc_o(bc));
  vlu_logical_unit u_dut (.clk_i, .srst_i, .issue_valid_i(iv), .op_i(op),
    .src2_is_imm_i(fl[2]), .dest_is_branch_i(fl[1]), .src_is_branch_i(fl[0]),
    .src1_i(a), .src2_i(b), .imm_i(im), .branch_condition_source_i(bc),
    .bsrc1_i(bc), .bsrc2_i(im[3:0]), .result_valid_o(rv), .result_o(res),
    .bresult_valid_o(bv), .bresult_o(bres), .illegal_instruction_trap_o(trap));
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Issue one operation and compare the general result a cycle later
  task automatic run(logic [5:0] o, logic [31:0] x, y, z, logic [3:0] c,
                     logic [2:0] f, logic [31:0] e);
    u_iss.issue(o, x, y, z, c, f);
    #1;
    chk("result", res, e);
    chk("valid", {31'h0, rv}, 32'h1);
  endtask : run
  // Branch result: bsrc1 from c, bsrc2 from the immediate's low bits
  task automatic brun(logic [5:0] o, logic [31:0] x, z, logic [3:0] c,
                      logic [2:0] f, logic [3:0] e);
    u_iss.issue(o, x, 32'h0, z, c, f);
    #1;
    chk("bresult", {27'h0, bv, bres}, {28'h1, e});
  endtask : brun
  task automatic t_logic();
    run(vlu_pkg::OP_AND, 32'hF0F0F0F0, 32'hFF00FF00, 0, 0, 0, 32'hF000F000);
    run(vlu_pkg::OP_ANDC, 32'hF0F0F0F0, 32'hFF00FF00, 0, 0, 0, 32'h0F000F00);
    run(vlu_pkg::OP_OR, 32'h0F0F0000, 32'h0000F0F0, 0, 0, 0, 32'h0F0FF0F0);
    run(vlu_pkg::OP_ORC, 32'hFFFFFFFF, 0, 32'h5, 0, 3'h4, 32'h5);
    run(vlu_pkg::OP_XOR, 32'h12345678, 0, '1, 0, 3'h4, 32'hEDCBA987);
    run(vlu_pkg::OP_SELECT, 32'h11, 32'h22, 0, 4'h1, 0, 32'h11);
    run(vlu_pkg::OP_SELECT, 32'h11, 0, 32'h33, 4'h0, 3'h4, 32'h33);
    run(vlu_pkg::OP_SELECT_F, 32'h11, 32'h22, 0, 4'h1, 0, 32'h22);
    run(vlu_pkg::OP_ANDL, 32'h2, 32'h4, 0, 0, 0, 32'h1);
    run(vlu_pkg::OP_NORL, 32'h0, 32'h0, 0, 0, 0, 32'h1);
    brun(vlu_pkg::OP_NANDL, 0, 32'h1, 4'h1, 3'h3, 4'h0);
    brun(vlu_pkg::OP_ANDL, 0, 32'h0, 4'h1, 3'h3, 4'h0);
    brun(vlu_pkg::OP_ORL, 0, 32'h1, 4'h0, 3'h3, 4'h1);
    brun(vlu_pkg::OP_CONV_I2B, 32'h100, 0, 0, 3'h2, 4'h1);
    brun(vlu_pkg::OP_MOV, 32'h5, 0, 0, 3'h2, 4'h5);
    brun(vlu_pkg::OP_MOV, 0, 0, 4'h9, 3'h3, 4'h9);
    run(vlu_pkg::OP_MOV, 0, 0, 0, 4'hA, 3'h1, 32'hA);
    run(vlu_pkg::OP_CONV_B2I, 0, 0, 0, 4'h1, 0, 32'h1);
    $display("logic test done");
  endtask : t_logic
  task automatic t_extract();
    run(vlu_pkg::OP_EXTRACT, 32'hF000, 0, 32'h6C, 0, 3'h4, '1);
    run(vlu_pkg::OP_EXTRACTU, 32'hF000, 0, 32'hFFFFFE6C, 0, 3'h4, 32'hF);
    run(vlu_pkg::OP_EXTRACTLU, 32'h87654321, 0, 32'h1E0, 0, 3'h4, 32'h87654321);
    run(vlu_pkg::OP_EXTRACTL, 32'h80000000, 0, 32'hF, 0, 3'h4, 32'hFFFF0000);
    run(vlu_pkg::OP_EXTRACTU, 32'hABCD0000, 0, 32'h1F0, 0, 3'h4, 32'hABCD);
    u_iss.issue(vlu_pkg::OP_EXTRACTU, '1, 0, 32'h1F1, 0, 3'h4);
    #1;
    chk("trap", {30'h0, trap, rv}, 32'h2);
    chk("trapres", res, 32'h0);
    run(vlu_pkg::OP_ROTL, 32'h12345678, 32'h8, 0, 0, 0, 32'h34567812);
    run(vlu_pkg::OP_ZXT, 32'hFFFF, 0, 32'h4, 0, 3'h4, 32'hF);
    run(vlu_pkg::OP_SXTH, 32'h8000, 0, 0, 0, 0, 32'hFFFF8000);
    run(vlu_pkg::OP_ZXTB, 32'h1FF, 0, 0, 0, 0, 32'hFF);
    run(vlu_pkg::OP_ROTL, 32'h80000001, 0, 32'h1, 0, 3'h4, 32'h3);
    run(vlu_pkg::OP_SHL, 32'h1, 32'd31, 0, 0, 0, 32'h80000000);
    run(vlu_pkg::OP_SHRU, 32'h80000000, 0, 32'd31, 0, 3'h4, 32'h1);
    run(vlu_pkg::OP_SXT, 32'hF0, 0, 32'h8, 0, 3'h4, 32'hFFFFFFF0);
    run(vlu_pkg::OP_SXTB, 32'h80, 0, 0, 0, 0, 32'hFFFFFF80);
    run(vlu_pkg::OP_ZXTH, 32'hFFFF8001, 0, 0, 0, 0, 32'h8001);
    $display("extract test done");
  endtask : t_extract
  task automatic t_packed();
    logic [31:0] x = 32'h11223344;
    logic [31:0] y = 32'hAABBCCDD;
    run(vlu_pkg::OP_BYTE_LANE_SELECT, x, y, 0, 4'h5, 0, 32'hAA22CC44);
    run(vlu_pkg::OP_BYTE_LANE_SELECT_NEGATED, x, y, 0, 4'h5, 0, 32'h11BB33DD);
    run(vlu_pkg::OP_WORD_FROM_BYTE_TWO, x, y, 0, 0, 0, 32'hCCDD1122);
    run(vlu_pkg::OP_DYNAMIC_RIGHT_EXTRACT, x, y, 0, 4'h1, 0, 32'hDD112233);
    run(vlu_pkg::OP_DYNAMIC_LEFT_EXTRACT, x, y, 0, 4'h1, 0, 32'hBBCCDD11);
    run(vlu_pkg::OP_TRUNCATING_BYTE_PACK, 32'h12345678, 32'h9ABCDEF0, 0, 0, 0,
        32'hBCF03478);
    run(vlu_pkg::OP_SATURATING_HALF_PACK, 32'h12345, 32'hFFFF0000, 0, 0, 0,
        32'h80007FFF);
    run(vlu_pkg::OP_UNSIGNED_SATURATING_BYTE_PACK, 32'h0100FFFF, 32'h007F8000,
        0, 0, 0, 32'h7F00FF00);
    run(vlu_pkg::OP_ROUNDING_HALF_PACK, 32'h18000, 32'hFFFF7FFF, 0, 0, 0,
        32'hFFFF0002);
    run(vlu_pkg::OP_LOW_HALF_JOIN, 32'h12345678, 32'h9ABCDEF0, 0, 0, 0,
        32'hDEF05678);
    run(vlu_pkg::OP_UNPACK_LOW, 32'h80FF, 0, 0, 0, 0, 32'h8000FF);
    run(vlu_pkg::OP_UNPACK_HIGH, x, 0, 0, 0, 0, 32'h00110022);
    run(vlu_pkg::OP_WORD_FROM_BYTE_ONE, x, y, 0, 0, 0, 32'hDD112233);
    run(vlu_pkg::OP_WORD_FROM_BYTE_THREE, x, y, 0, 0, 0, 32'hBBCCDD11);
    run(vlu_pkg::OP_BYTE_PERMUTE, x, 0, 32'h1B, 0, 3'h4, 32'h44332211);
    run(vlu_pkg::OP_SHUFFLE_BYTE_HIGH, x, y, 0, 0, 0, 32'hAA11BB22);
    run(vlu_pkg::OP_SHUFFLE_BYTE_LOW, x, y, 0, 0, 0, 32'hCC33DD44);
    run(vlu_pkg::OP_SHUFFLE_HALF_HIGH, x, y, 0, 0, 0, 32'hAABB1122);
    run(vlu_pkg::OP_SHUFFLE_HALF_LOW, x, y, 0, 0, 0, 32'hCCDD3344);
    run(vlu_pkg::OP_EVEN_BYTE_SHUFFLE, x, y, 0, 0, 0, 32'hBBDD2244);
    run(vlu_pkg::OP_ODD_BYTE_SHUFFLE, x, y, 0, 0, 0, 32'hAACC1133);
    $display("packed test done");
  endtask : t_packed
  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    t_logic();
    t_extract();
    t_packed();
    end_sim();
  end
endmodule : tb_top
